//--- rtl/ivl_consts.svh
`ifndef IVL_CONSTS_SVH
`define IVL_CONSTS_SVH

// ----------------------------------------
// Register byte offsets on the APB
// ----------------------------------------
`define IVL_OFS_IE 8'h00
`define IVL_OFS_FLAGS 8'h04
`define IVL_OFS_CTRL 8'h08
`define IVL_OFS_STATUS 8'h0C

// ----------------------------------------
// Enable and flag bit positions
// ----------------------------------------
`define IVL_BIT_WDT 0
`define IVL_BIT_OSC 1
`define IVL_BIT_KEY 3
`define IVL_BIT_NMI 4
`define IVL_BIT_ACCV 5
`define IVL_IE_MASK 8'h33
`define IVL_FLAG_MASK 8'h3B

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define IVL_CTRL_MODE_LSB 0
`define IVL_CTRL_MODE_MSB 2
`define IVL_CTRL_NMI_MODE 4
`define IVL_CTRL_DCO_RUN 5
`define IVL_MODE_LAST 3'h5

// ----------------------------------------
// Vector table and priorities
// ----------------------------------------
`define IVL_VEC_BASE 16'hFFE0
`define IVL_VEC_TOP 16'hFFFF
`define IVL_PRIO_RESET 15
`define IVL_PRIO_NMI 14
`define IVL_PRIO_WDT 10
`define IVL_PRIO_TCH0 9
`define IVL_PRIO_TSHARED 8
`define IVL_PRIO_PORT2 3
`define IVL_PRIO_PORT1 2
`define IVL_NUM_PRIO 16

// ----------------------------------------
// Clock enable patterns, top bit first: cpu, periph, aux, bias, xtal
// ----------------------------------------
`define IVL_CE_RUN 5'h1F
`define IVL_CE_SLEEP0 5'h0F
`define IVL_CE_SLEEP2 5'h07
`define IVL_CE_SLEEP3 5'h05
`define IVL_CE_SLEEP4 5'h00

`endif

//--- rtl/ivl_pkg.sv
package ivl_pkg;

  // Operating mode selected by software
  typedef enum logic [2:0] {
    MODE_RUN = 3'h0,
    MODE_SLEEP0 = 3'h1,
    MODE_SLEEP1 = 3'h2,
    MODE_SLEEP2 = 3'h3,
    MODE_SLEEP3 = 3'h4,
    MODE_SLEEP4 = 3'h5
  } ivl_mode_t;

  // Service sequencer, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REQ = 4'h2,
    ST_FETCH = 4'h4,
    ST_SERVICE = 4'h8
  } ivl_state_e_t;

  // All state of the controller
  typedef struct packed {
    ivl_state_e_t st;
    ivl_mode_t mode_sel;
    ivl_mode_t eff_mode;
    logic nmi_pin_mode;
    logic dco_in_run;
    logic [7:0] ie;
    logic [7:0] flags;
    logic reset_pend;
    logic pin_sync1;
    logic pin_sync2;
    logic pin_dly;
    logic sys_reset;
    logic [3:0] cur_prio;
    logic [15:0] vec_addr;
    logic [15:0] handler_addr;
    logic handler_vld;
    logic [15:0] svc_ack;
    logic [4:0] clk_en;
    logic [31:0] prdata;
  } ivl_state_t;

endpackage

//--- rtl/ivl_prio.sv
`timescale 1ns/100ps

// Fixed priority picker: the highest set index wins
module ivl_prio #(
  parameter int N = 16,
  parameter int W = 4
) (
  input logic [N-1:0] req,
  output logic any,
  output logic [W-1:0] idx
);

  logic [N-1:0] win;

  // ----------------------------------------
  // One winner per bit: set and nothing above it set
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_win
      if (g == N - 1) begin : g_top
        assign win[g] = req[g];
      end else begin : g_low
        assign win[g] = req[g] & ~(|req[N-1:g+1]);
      end
    end
  endgenerate

  // Encode the one-hot winner
  always_comb begin
    idx = '0;
    for (int i = 0; i < N; i++) begin
      if (win[i]) begin
        idx = W'(i);
      end
    end
  end

  assign any = |req;

endmodule

//--- rtl/ivl_top.sv
// Chosen here: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "ivl_consts.svh"

module ivl_top (
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic rst_nmi_pin_n,
  input logic wdt_expire,
  input logic wdt_interval_mode,
  input logic key_violation_in,
  input logic osc_fault_in,
  input logic flash_access_violation_in,
  input logic timer_channel0_flag,
  input logic timer_channel1_flag,
  input logic timer_channel2_flag,
  input logic timer_overflow_flag,
  input logic [7:0] port1_pin_flags,
  input logic [7:0] port2_pin_flags,
  input logic cpu_gie,
  input logic irq_ack,
  input logic irq_return,
  input logic [15:0] vector_rdata,
  input logic vector_rvalid,
  output logic irq_req,
  output logic [15:0] irq_vec_addr,
  output logic vector_fetch,
  output logic [15:0] handler_addr,
  output logic handler_valid,
  output logic [15:0] service_ack,
  output logic sys_reset_req,
  output ivl_pkg::ivl_mode_t eff_mode,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic aux_clk_en,
  output logic dco_bias_en,
  output logic xtal_en
);
  import ivl_pkg::*;

  // ----------------------------------------
  // State and decode
  // ----------------------------------------
  ivl_state_t cur_ff;
  ivl_state_t nxt_s;

  logic wr_acc;
  logic rd_setup;
  logic addr_ok;
  logic [15:0] req;
  logic req_any;
  logic [3:0] req_idx;
  logic pin_fall;
  logic pin_reset;
  logic wdt_reset_evt;
  logic awake;
  logic mode_wr;
  ivl_mode_t sel_mode;
  ivl_mode_t nxt_mode;

  // Zero wait states; unmapped offsets answer with an error
  assign addr_ok = (paddr == `IVL_OFS_IE) || (paddr == `IVL_OFS_FLAGS) ||
                   (paddr == `IVL_OFS_CTRL) || (paddr == `IVL_OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign wr_acc = psel & penable & pwrite & addr_ok;
  assign rd_setup = psel & ~penable & ~pwrite;

  // ----------------------------------------
  // Pin and event decode
  // ----------------------------------------
  // Only the second sync stage and its delayed copy are looked at
  assign pin_fall = cur_ff.pin_dly & ~cur_ff.pin_sync2;
  assign pin_reset = ~cur_ff.nmi_pin_mode & ~cur_ff.pin_sync2;
  assign wdt_reset_evt = (wdt_expire & ~wdt_interval_mode) | key_violation_in;

  // ----------------------------------------
  // Request vector, indexed by priority
  // ----------------------------------------
  always_comb begin
    req = '0;
    req[`IVL_PRIO_RESET] = cur_ff.reset_pend;
    // Global enable deliberately left out of this class
    req[`IVL_PRIO_NMI] = (cur_ff.flags[`IVL_BIT_NMI] & cur_ff.ie[`IVL_BIT_NMI]) |
                         (cur_ff.flags[`IVL_BIT_OSC] & cur_ff.ie[`IVL_BIT_OSC]) |
                         (cur_ff.flags[`IVL_BIT_ACCV] & cur_ff.ie[`IVL_BIT_ACCV]);
    req[`IVL_PRIO_WDT] = cur_ff.flags[`IVL_BIT_WDT] & cur_ff.ie[`IVL_BIT_WDT] &
                         wdt_interval_mode & cpu_gie;
    // Peripheral flags arrive already gated by their own enables
    req[`IVL_PRIO_TCH0] = timer_channel0_flag & cpu_gie;
    req[`IVL_PRIO_TSHARED] = (timer_channel1_flag | timer_channel2_flag |
                              timer_overflow_flag) & cpu_gie;
    req[`IVL_PRIO_PORT2] = (|port2_pin_flags) & cpu_gie;
    req[`IVL_PRIO_PORT1] = (|port1_pin_flags) & cpu_gie;
  end

  // Highest index wins when several are pending
  ivl_prio #(
    .N(`IVL_NUM_PRIO),
    .W(4)
  ) u_prio (
    .req(req),
    .any(req_any),
    .idx(req_idx)
  );

  // ----------------------------------------
  // Mode: awake while anything is pending or in service
  // ----------------------------------------
  // A mode written this cycle counts at once; decoding it here rather
  // than from the next-state copy keeps the mode logic free of a loop
  assign mode_wr = wr_acc && (paddr == `IVL_OFS_CTRL) &&
                   (pwdata[`IVL_CTRL_MODE_MSB:`IVL_CTRL_MODE_LSB] <= `IVL_MODE_LAST);
  assign sel_mode = mode_wr ? ivl_mode_t'(pwdata[`IVL_CTRL_MODE_MSB:`IVL_CTRL_MODE_LSB]) :
                    cur_ff.mode_sel;
  assign awake = req_any | (cur_ff.st != ST_IDLE);
  assign nxt_mode = awake ? MODE_RUN : sel_mode;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    nxt_s = cur_ff;
    nxt_s.handler_vld = 1'b0;
    nxt_s.svc_ack = '0;
    nxt_s.sys_reset = pin_reset | wdt_reset_evt;

    // Pin synchroniser
    nxt_s.pin_sync1 = rst_nmi_pin_n;
    nxt_s.pin_sync2 = cur_ff.pin_sync1;
    nxt_s.pin_dly = cur_ff.pin_sync2;

    // Software writes; flags clear on writing one
    if (wr_acc) begin
      case (paddr)
        `IVL_OFS_IE: begin
          nxt_s.ie = pwdata[7:0] & `IVL_IE_MASK;
        end
        `IVL_OFS_FLAGS: begin
          nxt_s.flags = cur_ff.flags & ~(pwdata[7:0] & `IVL_FLAG_MASK);
        end
        `IVL_OFS_CTRL: begin
          if (mode_wr) begin
            nxt_s.mode_sel = sel_mode;
          end
          nxt_s.nmi_pin_mode = pwdata[`IVL_CTRL_NMI_MODE];
          nxt_s.dco_in_run = pwdata[`IVL_CTRL_DCO_RUN];
        end
        default: begin
        end
      endcase
    end

    // Hardware sets win over a same-cycle software clear
    if (wdt_expire) begin
      nxt_s.flags[`IVL_BIT_WDT] = 1'b1;
    end
    if (key_violation_in) begin
      nxt_s.flags[`IVL_BIT_KEY] = 1'b1;
    end
    if (osc_fault_in) begin
      nxt_s.flags[`IVL_BIT_OSC] = 1'b1;
    end
    if (flash_access_violation_in) begin
      nxt_s.flags[`IVL_BIT_ACCV] = 1'b1;
    end
    if (cur_ff.nmi_pin_mode && pin_fall) begin
      nxt_s.flags[`IVL_BIT_NMI] = 1'b1;
    end
    // Pin reset forgets any earlier watchdog cause
    if (pin_reset) begin
      nxt_s.flags[`IVL_BIT_WDT] = 1'b0;
    end
    if (wdt_reset_evt || pin_reset) begin
      nxt_s.reset_pend = 1'b1;
    end

    // Service sequencer
    case (cur_ff.st)
      ST_IDLE: begin
        if (req_any) begin
          nxt_s.cur_prio = req_idx;
          nxt_s.vec_addr = `IVL_VEC_BASE | {11'h000, req_idx, 1'b0};
          nxt_s.st = ST_REQ;
        end
      end
      ST_REQ: begin
        if (irq_ack) begin
          nxt_s.st = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (vector_rvalid) begin
          nxt_s.handler_addr = vector_rdata;
          nxt_s.handler_vld = 1'b1;
          nxt_s.svc_ack[cur_ff.cur_prio] = 1'b1;
          // A reset cause still present at the fetch keeps the request alive
          if (cur_ff.cur_prio == 4'(`IVL_PRIO_RESET)) begin
            nxt_s.reset_pend = wdt_reset_evt | pin_reset;
          end
          nxt_s.st = ST_SERVICE;
        end
      end
      ST_SERVICE: begin
        // A reset request abandons the running handler
        if (irq_return || cur_ff.reset_pend) begin
          nxt_s.st = ST_IDLE;
        end
      end
      default: begin
        nxt_s.st = ST_IDLE;
      end
    endcase

    // Clock gating by effective mode; the field runs cpu, periph, aux,
    // bias, xtal from its top bit down, the same order as the status word
    nxt_s.eff_mode = nxt_mode;
    case (nxt_mode)
      MODE_RUN: begin
        // Everything on
        nxt_s.clk_en = `IVL_CE_RUN;
      end
      MODE_SLEEP0: begin
        // CPU clock off, peripheral and auxiliary clocks on
        nxt_s.clk_en = `IVL_CE_SLEEP0;
      end
      MODE_SLEEP1: begin
        // Bias stays only if the oscillator feeds the running mode
        nxt_s.clk_en = {3'h3, nxt_s.dco_in_run, 1'b1};
      end
      MODE_SLEEP2: begin
        // Peripheral clock off too; bias kept for a fast restart
        nxt_s.clk_en = `IVL_CE_SLEEP2;
      end
      MODE_SLEEP3: begin
        // Only the auxiliary clock and its crystal remain
        nxt_s.clk_en = `IVL_CE_SLEEP3;
      end
      MODE_SLEEP4: begin
        // Crystal halted; only an interrupt or a reset brings it back
        nxt_s.clk_en = `IVL_CE_SLEEP4;
      end
      default: begin
        // Unused codes are refused at the write; fail safe to all on
        nxt_s.clk_en = `IVL_CE_RUN;
      end
    endcase

    // Read data is captured in the setup phase, valid in the access phase
    if (rd_setup) begin
      case (paddr)
        `IVL_OFS_IE: begin
          nxt_s.prdata = {24'h00_0000, cur_ff.ie};
        end
        `IVL_OFS_FLAGS: begin
          nxt_s.prdata = {24'h00_0000, cur_ff.flags};
        end
        `IVL_OFS_CTRL: begin
          nxt_s.prdata = {26'h000_0000, cur_ff.dco_in_run, cur_ff.nmi_pin_mode,
                          1'b0, cur_ff.mode_sel};
        end
        `IVL_OFS_STATUS: begin
          nxt_s.prdata = {11'h000, cur_ff.clk_en, 1'b0, cur_ff.eff_mode,
                          cur_ff.cur_prio, cur_ff.reset_pend, cur_ff.pin_sync2,
                          2'h0, cur_ff.st};
        end
        default: begin
          nxt_s.prdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff <= '0;
      cur_ff.st <= ST_IDLE;
      cur_ff.mode_sel <= MODE_RUN;
      cur_ff.eff_mode <= MODE_RUN;
      cur_ff.pin_sync1 <= 1'b1;
      cur_ff.pin_sync2 <= 1'b1;
      cur_ff.pin_dly <= 1'b1;
      cur_ff.clk_en <= `IVL_CE_RUN;
      cur_ff.vec_addr <= `IVL_VEC_TOP - 16'h0001;
    end else begin
      cur_ff <= nxt_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Bus side
  assign prdata = cur_ff.prdata;

  // Interrupt handshake towards the CPU
  assign irq_req = (cur_ff.st == ST_REQ);
  assign irq_vec_addr = cur_ff.vec_addr;
  assign vector_fetch = (cur_ff.st == ST_FETCH);
  assign handler_addr = cur_ff.handler_addr;
  assign handler_valid = cur_ff.handler_vld;
  assign service_ack = cur_ff.svc_ack;
  assign sys_reset_req = cur_ff.sys_reset;

  // Mode and clock gating, all straight from flip-flops
  assign eff_mode = cur_ff.eff_mode;
  assign cpu_clk_en = cur_ff.clk_en[4];
  assign periph_clk_en = cur_ff.clk_en[3];
  assign aux_clk_en = cur_ff.clk_en[2];
  assign dco_bias_en = cur_ff.clk_en[1];
  assign xtal_en = cur_ff.clk_en[0];

endmodule

//--- test/ivl_cpu_model.sv
`timescale 1ns/100ps
// ----
// CPU side model
// ----
module ivl_cpu_model (
  input logic pclk,
  input logic [3:0] dly,
  input logic irq_req,
  input logic [15:0] irq_vec_addr,
  input logic vector_fetch,
  input logic handler_valid,
  output logic irq_ack,
  output logic irq_return,
  output logic [15:0] vector_rdata,
  output logic vector_rvalid
);
  logic [4:0] w = 5'h00;
  logic in_svc = 1'b0;
  initial begin
    irq_ack = 1'b0;
    irq_return = 1'b0;
    vector_rdata = 16'h0000;
    vector_rvalid = 1'b0;
  end
  // Ack and fetch wait dly cycles, the return dly+7, so one model serves prompt and slow
  always @(posedge pclk) begin
    irq_ack <= 1'b0;
    vector_rvalid <= 1'b0;
    irq_return <= 1'b0;
    vector_rdata <= ~vector_rdata; // Word is not held between fetches
    w <= w + 5'h01;
    if (handler_valid) begin
      in_svc <= 1'b1;
      w <= 5'h00;
    end else if (in_svc && w > {1'b0, dly} + 5'h06) begin
      irq_return <= 1'b1;
      in_svc <= 1'b0;
    end else if (irq_req && !irq_ack && w >= {1'b0, dly}) begin
      irq_ack <= 1'b1;
      w <= 5'h00;
    end else if (vector_fetch && !vector_rvalid && w >= {1'b0, dly}) begin
      vector_rvalid <= 1'b1;
      vector_rdata <= {irq_vec_addr[7:0], ~irq_vec_addr[7:0]};
      w <= 5'h00;
    end else if (!irq_req && !vector_fetch && !in_svc) begin
      w <= 5'h00;
    end
  end
endmodule

//--- test/ivl_top_chk.sv
`timescale 1ns/100ps
// ----
// Port checker
// ----
module ivl_top_chk (
  input logic pclk,
  input logic presetn,
  input logic irq_req,
  input logic [15:0] irq_vec_addr,
  input logic vector_fetch,
  input logic vector_rvalid,
  input logic [15:0] vector_rdata,
  input logic handler_valid,
  input logic [15:0] handler_addr,
  input logic [15:0] service_ack,
  input logic sys_reset_req,
  input logic wdt_expire,
  input logic wdt_interval_mode,
  input logic key_violation_in,
  input ivl_pkg::ivl_mode_t eff_mode,
  input logic cpu_clk_en,
  input logic periph_clk_en,
  input logic aux_clk_en,
  input logic dco_bias_en,
  input logic xtal_en
);
  import ivl_pkg::*;
  logic [4:0] ce;
  // Enables in one field, cpu first
  assign ce = {cpu_clk_en, periph_clk_en, aux_clk_en, dco_bias_en, xtal_en};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Vector, service, reset and wake relations
  property p_vec; irq_req |-> irq_vec_addr >= 16'hFFE0 && !irq_vec_addr[0]; endproperty
  a_vec: assert property (p_vec) else $error("vector outside table");
  property p_hnd; vector_fetch && vector_rvalid |=> handler_addr == $past(vector_rdata); endproperty
  a_hnd: assert property (p_hnd) else $error("handler word not taken");
  property p_ack; handler_valid |-> service_ack == 16'h0001 << irq_vec_addr[4:1]; endproperty
  a_ack: assert property (p_ack) else $error("ack does not match vector");
  property p_rst; key_violation_in || (wdt_expire && !wdt_interval_mode) |=> sys_reset_req; endproperty
  a_rst: assert property (p_rst) else $error("no system reset");
  property p_wake; irq_req |=> eff_mode == MODE_RUN; endproperty
  a_wake: assert property (p_wake) else $error("no wake on request");
  // Clock gating per mode; bits not fixed by a mode are left free
  property p_run; eff_mode == MODE_RUN |-> ce[4:2] == 3'h7; endproperty
  a_run: assert property (p_run) else $error("run clocks wrong");
  property p_s0; eff_mode == MODE_SLEEP0 |-> ce[4:2] == 3'h3; endproperty
  a_s0: assert property (p_s0) else $error("sleep 0 clocks wrong");
  property p_s1; eff_mode == MODE_SLEEP1 |-> ce[4:2] == 3'h3; endproperty
  a_s1: assert property (p_s1) else $error("sleep 1 clocks wrong");
  property p_s2; eff_mode == MODE_SLEEP2 |-> ce[4:1] == 4'h3; endproperty
  a_s2: assert property (p_s2) else $error("sleep 2 clocks wrong");
  property p_s3; eff_mode == MODE_SLEEP3 |-> ce[4:1] == 4'h2; endproperty
  a_s3: assert property (p_s3) else $error("sleep 3 clocks wrong");
  property p_s4; eff_mode == MODE_SLEEP4 |-> ce == 5'h00; endproperty
  a_s4: assert property (p_s4) else $error("sleep 4 clocks wrong");
endmodule

bind ivl_top ivl_top_chk u_chk (.pclk, .presetn, .irq_req, .irq_vec_addr, .vector_fetch,
  .vector_rvalid, .vector_rdata, .handler_valid, .handler_addr, .service_ack, .sys_reset_req,
  .wdt_expire, .wdt_interval_mode, .key_violation_in, .eff_mode, .cpu_clk_en, .periph_clk_en,
  .aux_clk_en, .dco_bias_en, .xtal_en);

//--- test/ivl_top_tb.sv
`timescale 1ns/100ps
module ivl_top_tb;
  import ivl_pkg::*;
  logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, pin_n = 1, wdt = 0, key = 0;
  logic osc = 0, gie = 1, e, pready, pslverr, irq_ack, irq_return, vector_rvalid, irq_req;
  logic vector_fetch, handler_valid, sys_reset_req, cpu_clk_en, periph_clk_en, aux_clk_en;
  logic dco_bias_en, xtal_en;
  logic wim = 0, accv = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic [15:0] vector_rdata, irq_vec_addr, handler_addr, service_ack;
  logic [19:0] src = 0;
  logic [3:0] dly = 0;
  logic [2:0] m;
  ivl_mode_t eff_mode;
  int n_errors = 0, samples_checked = 0, k;
  logic [19:0] tsrc [8] = '{20'h0_0001, 20'h0_0002, 20'h0_0004, 20'h0_0008, 20'h8_0000,
    20'h0_0010, 20'h0_0011, 20'h0_1800};
  logic [15:0] tvec [8] = '{16'hFFF2, 16'hFFF0, 16'hFFF0, 16'hFFF0, 16'hFFE6, 16'hFFE4,
    16'hFFF2, 16'hFFE6};
  logic [7:0] tctl [8] = '{8'h00, 8'h01, 8'h02, 8'h22, 8'h03, 8'h04, 8'h05, 8'h06};

  ivl_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .rst_nmi_pin_n(pin_n), .wdt_expire(wdt), .wdt_interval_mode(wim),
    .key_violation_in(key), .osc_fault_in(osc), .flash_access_violation_in(accv),
    .timer_channel0_flag(src[0]), .timer_channel1_flag(src[1]), .timer_channel2_flag(src[2]),
    .timer_overflow_flag(src[3]), .port1_pin_flags(src[11:4]), .port2_pin_flags(src[19:12]),
    .cpu_gie(gie), .irq_ack, .irq_return, .vector_rdata, .vector_rvalid, .irq_req,
    .irq_vec_addr, .vector_fetch, .handler_addr, .handler_valid, .service_ack, .sys_reset_req,
    .eff_mode, .cpu_clk_en, .periph_clk_en, .aux_clk_en, .dco_bias_en, .xtal_en);
  ivl_cpu_model cpu (.pclk, .dly, .irq_req, .irq_vec_addr, .vector_fetch, .handler_valid,
    .irq_ack, .irq_return, .vector_rdata, .vector_rvalid);

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ----
  // Shared tasks
  // ----
  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  task complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  function logic sg(input int s);
    return s == 0 ? sys_reset_req : s == 1 ? irq_req : s == 2 ? handler_valid : irq_return;
  endfunction
  // Bounded wait; a hang ends the run as a failure
  task wt(input int s);
    int i;
    i = 0;
    while (sg(s) !== 1'b1 && i < 100) begin
      @(posedge pclk);
      i++;
    end
    if (i >= 100) begin
      n_errors++;
      complete_run;
    end
  endtask
  // APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    i = 0;
    while (pready !== 1'b1 && i < 100) begin
      @(posedge pclk);
      i++;
    end
    if (i >= 100) begin
      n_errors++;
      complete_run;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One service round; flags cleared while in the handler
  task svc(input logic [15:0] v);
    wt(2);
    chk("vector", v, irq_vec_addr);
    chk("handler", {v[7:0], ~v[7:0]}, handler_addr);
    chk("ack", 32'h0000_0001 << v[4:1], service_ack);
    src <= '0;
    apb(1'b1, 8'h04, 32'h0000_00FF);
    wt(3);
    @(posedge pclk);
  endtask

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset vector", 16'hFFFE, irq_vec_addr);
    chk("run clocks", 5'h1F, {cpu_clk_en, periph_clk_en, aux_clk_en, dco_bias_en, xtal_en});
    apb(1'b0, 8'h00, 32'h0);
    chk("ie reset", 32'h0, q);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, e);
    for (k = 0; k < 8; k++) begin
      dly <= k[0] ? 4'h3 : 4'h0;
      src <= tsrc[k];
      svc(tvec[k]);
    end
    gie <= 1'b0;
    src <= 20'h0_0010;
    repeat (8) @(posedge pclk);
    chk("masked", 32'h0, irq_req);
    src <= '0;
    osc <= 1'b1;
    @(posedge pclk);
    osc <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("nmi disabled", 32'h0, irq_req);
    apb(1'b1, 8'h04, 32'h0000_00FF);
    apb(1'b1, 8'h00, 32'h0000_0022);
    osc <= 1'b1;
    @(posedge pclk);
    osc <= 1'b0;
    svc(16'hFFFC);
    accv <= 1'b1;
    @(posedge pclk);
    accv <= 1'b0;
    svc(16'hFFFC);
    gie <= 1'b1;
    wim <= 1'b1;
    apb(1'b1, 8'h00, 32'h0000_0001);
    wdt <= 1'b1;
    @(posedge pclk);
    wdt <= 1'b0;
    svc(16'hFFF4);
    wim <= 1'b0;
    apb(1'b1, 8'h08, 32'h0000_0004);
    src <= 20'h0_0010;
    svc(16'hFFE4);
    repeat (2) @(posedge pclk);
    chk("resume", MODE_SLEEP3, eff_mode);
    // Every mode code, the unused code 6 must leave the mode alone
    for (k = 0; k < 8; k++) begin
      m = (tctl[k][2:0] == 3'h6) ? 3'h5 : tctl[k][2:0];
      apb(1'b1, 8'h08, tctl[k]);
      repeat (2) @(posedge pclk);
      chk("mode", m, eff_mode);
      apb(1'b0, 8'h0C, 32'h0);
      chk("status mode", m, q[14:12]);
      if (m == 3'h2) chk("bias", tctl[k][5], dco_bias_en);
    end
    apb(1'b1, 8'h08, 32'h0000_0010);
    apb(1'b1, 8'h00, 32'h0000_0010);
    pin_n <= 1'b0;
    svc(16'hFFFC);
    chk("nmi pin no reset", 32'h0, sys_reset_req);
    pin_n <= 1'b1;
    apb(1'b1, 8'h08, 32'h0);
    key <= 1'b1;
    @(posedge pclk);
    key <= 1'b0;
    wt(0);
    repeat (4) @(posedge pclk);
    wdt <= 1'b1;
    @(posedge pclk);
    wdt <= 1'b0;
    wt(0);
    repeat (4) @(posedge pclk);
    pin_n <= 1'b0;
    wt(0);
    repeat (3) @(posedge pclk);
    pin_n <= 1'b1;
    svc(16'hFFFE);
    complete_run;
  end
endmodule
